// ### logic/mrs_slave.sv
// Slave-side request interpreter: decode, execute and answer frames
// Contract
// R1: master waits at least 3 ms after a response before its next request.
// R2: address zero is broadcast; act on it, never transmit a reply.
// R3: read request holds address, function, start, count 1..7Dh, CRC.
// R4: read reply echoes address and function, byte count twice count, data.
// R5: failure reply is address, function with top bit, exception 01..04.
// R6: reads reach program or process objects; process reads need alignment; no alignment check is made here.
// R7: single write holds address, function 06h, register, value, CRC.
// R8: successful single write reply is identical to the request.
// R9: single write targets process-data objects.
// R10: diagnostic 0Ah clears all counters and the diagnostic register.
// R11: diagnostic 0Bh returns the bus message count.
// R12: 0Ch returns communication error count, 0Dh exception count.
// R13: 0Eh returns own message count, 0Fh unanswered request count.
// R14: 10h returns negative acknowledge count, 11h busy count; no event feeds counter 5, so 10h always returns zero.
// R15: 12h returns the receive overrun character count.
// R16: function 65h streams the dictionary; 55h starts, AAh continues.
// R17: function 66h streams one array or record; 55h starts, AAh continues.
// R18: addresses, counts and register values travel high byte first.
// R19: data of functions 2Bh, 65h, 66h travel low byte first.
// R20: unsupported function or subfunction answers exception 01, counted.
// R21: bad CRC frames are dropped silently and counted as errors.
module mrs_slave (
    input wire logic CLK_SYS_I,
    input wire logic SYS_RST_I,
    input wire logic [7:0] NODE_ADDR_I,
    input wire logic RX_VALID_I,
    input wire logic [7:0] RX_DATA_I,
    input wire logic RX_FRAME_END_I,
    input wire logic RX_OVERRUN_I,
    output logic TX_VALID_O,
    output logic [7:0] TX_DATA_O,
    output logic TX_LAST_O,
    input wire logic TX_READY_I,
    output logic OBJ_RD_O,
    output logic OBJ_WR_O,
    output logic [1:0] OBJ_SPACE_O,
    output logic [15:0] OBJ_ADDR_O,
    output logic [15:0] OBJ_WDATA_O,
    output logic [15:0] OBJ_INDEX_O,
    input wire logic [15:0] OBJ_RDATA_I,
    input wire logic OBJ_ACK_I,
    input wire logic OBJ_ERR_I,
    output logic BUSY_O,
    output logic [15:0] DIAG_O
);

    mrs_pkg::mrs_state_t state;
    logic [7:0] rx_buf [0:7];
    logic [7:0] rx_cnt;
    logic [15:0] rx_crc;
    logic [7:0] tx_buf [0:mrs_pkg::TX_DEPTH-1];
    logic [8:0] tx_len;
    logic [8:0] tx_pos;
    logic [15:0] tx_crc;
    logic [7:0] tx_byte;
    logic [15:0] next_tx_crc;
    logic [7:0] q_fc;
    logic [7:0] q_len;
    logic [15:0] q_w1;
    logic [15:0] q_w2;
    logic q_bcast;
    logic [7:0] exc_code;
    logic [7:0] rd_left;
    logic strm_mode;
    logic strm_on;
    logic [7:0] strm_fc;
    logic [15:0] strm_ptr;
    logic [7:0] ev;
    logic ev_clear;
    logic [15:0] cnt [0:7];
    logic diag_hit;
    logic [15:0] diag_val;
    logic [8:0] tx_len_p1;

    // Handshake outputs
    assign TX_VALID_O = (state == mrs_pkg::ST_SEND);
    assign TX_DATA_O = tx_byte;
    assign TX_LAST_O = TX_VALID_O && (tx_pos == tx_len + 9'h001);
    assign OBJ_RD_O = (state == mrs_pkg::ST_RD_WAIT);
    assign OBJ_WR_O = (state == mrs_pkg::ST_WR_WAIT);
    assign BUSY_O = (state != mrs_pkg::ST_IDLE);
    assign next_tx_crc = mrs_pkg::mrs_crc_byte(tx_crc, tx_byte);
    assign tx_len_p1 = tx_len + 9'h001;

    // Receive capture and running checksum
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            rx_cnt <= 8'h00;
            rx_crc <= mrs_pkg::CRC_INIT;
        end else if (RX_FRAME_END_I) begin
            rx_cnt <= 8'h00;
            rx_crc <= mrs_pkg::CRC_INIT;
        end else if (RX_VALID_I) begin
            if (rx_cnt < mrs_pkg::RX_KEEP) begin
                rx_buf[rx_cnt[2:0]] <= RX_DATA_I;
            end
            if (rx_cnt != 8'hFF) begin
                rx_cnt <= rx_cnt + 8'h01;
            end
            rx_crc <= mrs_pkg::mrs_crc_byte(rx_crc, RX_DATA_I);
        end
    end

    // Diagnostic counter selection
    always_comb begin
        diag_hit = (q_w1 >= mrs_pkg::SUB_CNT_FIRST) &&
                   (q_w1 <= mrs_pkg::SUB_CNT_LAST);
        diag_val = cnt[3'(q_w1 - mrs_pkg::SUB_CNT_FIRST)]; // R11 R12 R13 R14 R15
    end

    // Request sequencer, reply builder and transmitter
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            state <= mrs_pkg::ST_IDLE;
            tx_len <= 9'h000;
            tx_pos <= 9'h000;
            tx_crc <= mrs_pkg::CRC_INIT;
            tx_byte <= 8'h00;
            q_fc <= 8'h00;
            q_len <= 8'h00;
            q_w1 <= 16'h0000;
            q_w2 <= 16'h0000;
            q_bcast <= 1'b0;
            exc_code <= 8'h00;
            rd_left <= 8'h00;
            strm_mode <= 1'b0;
            strm_on <= 1'b0;
            strm_fc <= 8'h00;
            strm_ptr <= 16'h0000;
            ev <= 8'h00;
            ev_clear <= 1'b0;
            OBJ_SPACE_O <= mrs_pkg::SPACE_HOLD;
            OBJ_ADDR_O <= 16'h0000;
            OBJ_WDATA_O <= 16'h0000;
            OBJ_INDEX_O <= 16'h0000;
        end else begin
            ev <= {RX_OVERRUN_I, 7'h00};
            ev_clear <= 1'b0;
            if (RX_FRAME_END_I && state != mrs_pkg::ST_IDLE) begin
                ev[mrs_pkg::CNT_BUSY] <= 1'b1;
            end
            unique case (state)
                mrs_pkg::ST_IDLE: begin
                    if (RX_FRAME_END_I) begin
                        if (rx_cnt < mrs_pkg::LEN_MIN || rx_crc != 16'h0000)
                        begin
                            ev[mrs_pkg::CNT_COMM] <= 1'b1; // R21
                        end else begin
                            ev[mrs_pkg::CNT_BUS] <= 1'b1;
                            if (rx_buf[0] == NODE_ADDR_I ||
                                rx_buf[0] == mrs_pkg::BCAST_ADDR) begin
                                ev[mrs_pkg::CNT_SRV] <= 1'b1;
                                q_bcast <= (rx_buf[0] == mrs_pkg::BCAST_ADDR);
                                q_fc <= rx_buf[1];
                                q_len <= rx_cnt;
                                q_w1 <= {rx_buf[2], rx_buf[3]}; // R18
                                q_w2 <= {rx_buf[4], rx_buf[5]};
                                tx_buf[0] <= NODE_ADDR_I;
                                tx_buf[1] <= rx_buf[1];
                                state <= mrs_pkg::ST_EXEC;
                            end
                        end
                    end
                end
                mrs_pkg::ST_EXEC: begin
                    exc_code <= mrs_pkg::EXC_ILL_VALUE;
                    state <= mrs_pkg::ST_EXC;
                    unique case (q_fc)
                        mrs_pkg::FC_RD_HOLD, mrs_pkg::FC_RD_INPUT: begin
                            if (q_len == mrs_pkg::LEN_FIXED &&
                                q_w2 != 16'h0000 &&
                                q_w2 <= mrs_pkg::RD_CNT_MAX) begin // R3
                                OBJ_SPACE_O <= (q_fc == mrs_pkg::FC_RD_HOLD) ?
                                    mrs_pkg::SPACE_HOLD : mrs_pkg::SPACE_INPUT;
                                OBJ_ADDR_O <= q_w1;
                                rd_left <= q_w2[7:0];
                                tx_buf[2] <= {q_w2[6:0], 1'b0}; // R4
                                tx_len <= 9'h003;
                                strm_mode <= 1'b0;
                                state <= mrs_pkg::ST_RD_WAIT;
                            end
                        end
                        mrs_pkg::FC_WR_SINGLE: begin
                            if (q_len == mrs_pkg::LEN_FIXED) begin // R7
                                OBJ_SPACE_O <= mrs_pkg::SPACE_HOLD; // R9
                                OBJ_ADDR_O <= q_w1;
                                OBJ_WDATA_O <= q_w2;
                                tx_buf[2] <= q_w1[15:8]; // R8
                                tx_buf[3] <= q_w1[7:0];
                                tx_buf[4] <= q_w2[15:8];
                                tx_buf[5] <= q_w2[7:0];
                                state <= mrs_pkg::ST_WR_WAIT;
                            end
                        end
                        mrs_pkg::FC_DIAG: begin
                            if (q_len != mrs_pkg::LEN_FIXED) begin
                                exc_code <= mrs_pkg::EXC_ILL_VALUE;
                            end else if (q_w1 == mrs_pkg::SUB_CLEAR ||
                                         diag_hit) begin
                                ev_clear <= (q_w1 == mrs_pkg::SUB_CLEAR); // R10
                                tx_buf[2] <= q_w1[15:8];
                                tx_buf[3] <= q_w1[7:0];
                                tx_buf[4] <= diag_hit ? diag_val[15:8] :
                                             q_w2[15:8];
                                tx_buf[5] <= diag_hit ? diag_val[7:0] :
                                             q_w2[7:0];
                                tx_len <= 9'h006;
                                state <= mrs_pkg::ST_DONE;
                            end else begin
                                exc_code <= mrs_pkg::EXC_ILL_FUNC; // R20
                            end
                        end
                        mrs_pkg::FC_DUMP_DICT, mrs_pkg::FC_DUMP_REC: begin
                            tx_buf[2] <= q_w1[15:8];
                            tx_buf[3] <= 8'h00;
                            tx_len <= 9'h004;
                            rd_left <= mrs_pkg::STRM_WORDS;
                            strm_mode <= 1'b1;
                            OBJ_SPACE_O <= (q_fc == mrs_pkg::FC_DUMP_DICT) ?
                                mrs_pkg::SPACE_DICT : mrs_pkg::SPACE_REC;
                            if (q_w1[15:8] == mrs_pkg::STRM_START &&
                                (q_fc == mrs_pkg::FC_DUMP_DICT ||
                                 q_len >= mrs_pkg::LEN_STRM_REC)) begin // R16 R17
                                strm_on <= 1'b1;
                                strm_fc <= q_fc;
                                OBJ_ADDR_O <= 16'h0000;
                                OBJ_INDEX_O <= {q_w1[7:0], q_w2[15:8]};
                                state <= mrs_pkg::ST_RD_WAIT;
                            end else if (q_w1[15:8] == mrs_pkg::STRM_NEXT &&
                                         q_len >= mrs_pkg::LEN_STRM_NEXT &&
                                         strm_on && strm_fc == q_fc) begin
                                OBJ_ADDR_O <= strm_ptr; // R16 R17
                                state <= mrs_pkg::ST_RD_WAIT;
                            end else if (q_w1[15:8] != mrs_pkg::STRM_START &&
                                         q_w1[15:8] != mrs_pkg::STRM_NEXT) begin
                                exc_code <= mrs_pkg::EXC_ILL_FUNC; // R20
                            end
                        end
                        default: begin
                            exc_code <= mrs_pkg::EXC_ILL_FUNC; // R20
                        end
                    endcase
                end
                mrs_pkg::ST_RD_WAIT: begin
                    if (OBJ_ACK_I) begin
                        if (strm_mode) begin
                            tx_buf[tx_len[7:0]] <= OBJ_RDATA_I[7:0]; // R19
                            tx_buf[tx_len_p1[7:0]] <= OBJ_RDATA_I[15:8];
                            tx_buf[3] <= tx_buf[3] + 8'h02;
                            strm_ptr <= OBJ_ADDR_O + 16'h0001;
                        end else begin
                            tx_buf[tx_len[7:0]] <= OBJ_RDATA_I[15:8]; // R18
                            tx_buf[tx_len_p1[7:0]] <= OBJ_RDATA_I[7:0];
                        end
                        tx_len <= tx_len + 9'h002;
                        OBJ_ADDR_O <= OBJ_ADDR_O + 16'h0001;
                        rd_left <= rd_left - 8'h01;
                        if (rd_left == 8'h01) begin
                            state <= mrs_pkg::ST_DONE;
                        end
                    end else if (OBJ_ERR_I) begin
                        if (strm_mode) begin
                            strm_on <= 1'b0;
                            state <= mrs_pkg::ST_DONE;
                        end else begin
                            exc_code <= mrs_pkg::EXC_ILL_ADDR; // R6
                            state <= mrs_pkg::ST_EXC;
                        end
                    end
                end
                mrs_pkg::ST_WR_WAIT: begin
                    if (OBJ_ACK_I) begin
                        tx_len <= 9'h006; // R8
                        state <= mrs_pkg::ST_DONE;
                    end else if (OBJ_ERR_I) begin
                        exc_code <= mrs_pkg::EXC_ILL_ADDR;
                        state <= mrs_pkg::ST_EXC;
                    end
                end
                mrs_pkg::ST_EXC: begin
                    tx_buf[1] <= q_fc | mrs_pkg::FC_EXC_FLAG; // R5
                    tx_buf[2] <= exc_code;
                    tx_len <= 9'h003;
                    ev[mrs_pkg::CNT_EXC] <= 1'b1; // R20
                    state <= mrs_pkg::ST_DONE;
                end
                mrs_pkg::ST_DONE: begin
                    tx_pos <= 9'h000;
                    tx_crc <= mrs_pkg::CRC_INIT;
                    tx_byte <= tx_buf[0];
                    if (q_bcast) begin
                        ev[mrs_pkg::CNT_NORESP] <= 1'b1; // R2
                        state <= mrs_pkg::ST_IDLE;
                    end else begin
                        state <= mrs_pkg::ST_SEND;
                    end
                end
                mrs_pkg::ST_SEND: begin
                    if (TX_READY_I) begin
                        tx_pos <= tx_pos + 9'h001;
                        if (tx_pos < tx_len) begin
                            tx_crc <= next_tx_crc;
                        end
                        if (tx_pos_p1_lt()) begin
                            tx_byte <= tx_buf[tx_pos_next()];
                        end else if (tx_pos + 9'h001 == tx_len) begin
                            tx_byte <= next_tx_crc[7:0];
                        end else if (tx_pos == tx_len) begin
                            tx_byte <= tx_crc[15:8];
                        end else begin
                            state <= mrs_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Next payload index checks for the transmitter
    function automatic logic tx_pos_p1_lt();
        return (tx_pos + 9'h001) < tx_len;
    endfunction

    function automatic logic [7:0] tx_pos_next();
        logic [8:0] p;
        p = tx_pos + 9'h001;
        return p[7:0];
    endfunction

    // Event counters; an event in the clearing cycle survives
    always_ff @(posedge CLK_SYS_I) begin
        for (int i = 0; i < 8; i++) begin
            if (SYS_RST_I) begin
                cnt[i] <= 16'h0000;
            end else if (ev[i]) begin
                cnt[i] <= ev_clear ? 16'h0001 : cnt[i] + 16'h0001;
            end else if (ev_clear) begin
                cnt[i] <= 16'h0000; // R10
            end
        end
    end

    // Diagnostic register: sticky error summary
    always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
            DIAG_O <= 16'h0000;
        end else begin
            DIAG_O <= (ev_clear ? 16'h0000 : DIAG_O) |
                {13'h0000, ev[mrs_pkg::CNT_BUSY], ev[mrs_pkg::CNT_OVR],
                 ev[mrs_pkg::CNT_COMM]}; // R10
        end
    end

    default clocking dcb @(posedge CLK_SYS_I);
    endclocking
    default disable iff (SYS_RST_I);

    sequence s_reply_ready;
        state == mrs_pkg::ST_DONE && !q_bcast;
    endsequence

    sequence s_exec_fc(logic [7:0] f);
        state == mrs_pkg::ST_EXEC && q_fc == f;
    endsequence

    bcast_silent_a: assert property ( // R2
        TX_VALID_O |-> !q_bcast)
        else $error("reply sent for broadcast");
    rd_count_a: assert property ( // R4
        s_reply_ready and tx_buf[1] == mrs_pkg::FC_RD_HOLD |->
        tx_buf[2] == {q_w2[6:0], 1'b0} && tx_len == 9'(3 + 2 * q_w2))
        else $error("read reply byte count wrong");
    exc_frame_a: assert property ( // R5
        s_reply_ready and tx_buf[1][7] |-> tx_len == 9'h003 &&
        tx_buf[1] == (q_fc | 8'h80) && tx_buf[2] >= 8'h01 &&
        tx_buf[2] <= 8'h04)
        else $error("exception frame malformed");
    wr_echo_a: assert property ( // R8
        s_reply_ready and tx_buf[1] == mrs_pkg::FC_WR_SINGLE |->
        tx_len == 9'h006 && {tx_buf[2], tx_buf[3]} == q_w1 &&
        {tx_buf[4], tx_buf[5]} == q_w2)
        else $error("write reply is not an echo");
    crc_drop_a: assert property ( // R21
        state == mrs_pkg::ST_IDLE && RX_FRAME_END_I &&
        rx_crc != 16'h0000 |=> state == mrs_pkg::ST_IDLE ##1
        cnt[mrs_pkg::CNT_COMM] == $past(cnt[mrs_pkg::CNT_COMM], 2) + 16'h1)
        else $error("bad checksum frame not dropped");
    clear_cnt_a: assert property ( // R10
        ev_clear && ev == 8'h00 |=> cnt[0] == 16'h0 && cnt[2] == 16'h0 &&
        cnt[7] == 16'h0 && DIAG_O == 16'h0)
        else $error("counters not cleared");
    diag_bus_a: assert property ( // R11
        s_exec_fc(mrs_pkg::FC_DIAG) and q_w1 == 16'h000B &&
        q_len == 8'h08 |=> {tx_buf[4], tx_buf[5]} == $past(cnt[0]))
        else $error("bus message count not returned");
    unsup_fc_a: assert property ( // R20
        s_exec_fc(8'h07) |=> state == mrs_pkg::ST_EXC &&
        exc_code == 8'h01 ##1 ev[mrs_pkg::CNT_EXC])
        else $error("unsupported function not refused");
    rd_range_a: assert property ( // R3
        s_exec_fc(mrs_pkg::FC_RD_INPUT) and q_w2 > 16'h007D |=>
        state == mrs_pkg::ST_EXC && exc_code == 8'h03)
        else $error("read count range not checked");
    hi_first_a: assert property ( // R18
        state == mrs_pkg::ST_RD_WAIT && OBJ_ACK_I && !strm_mode |=>
        tx_buf[8'(tx_len - 9'h002)] == $past(OBJ_RDATA_I[15:8]))
        else $error("register value not high byte first");
    lo_first_a: assert property ( // R19
        state == mrs_pkg::ST_RD_WAIT && OBJ_ACK_I && strm_mode |=>
        tx_buf[8'(tx_len - 9'h002)] == $past(OBJ_RDATA_I[7:0]))
        else $error("stream value not low byte first");
    tx_hold_a: assert property ( // transmit byte held while stalled
        TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O))
        else $error("transmit byte changed while stalled");

endmodule

// ### logic/mrs_pkg.sv
// Constants, state type and checksum function for the request interpreter
package mrs_pkg;

    // Function codes
    localparam logic [7:0] FC_RD_HOLD = 8'h03;
    localparam logic [7:0] FC_RD_INPUT = 8'h04;
    localparam logic [7:0] FC_WR_SINGLE = 8'h06;
    localparam logic [7:0] FC_DIAG = 8'h08;
    localparam logic [7:0] FC_DUMP_DICT = 8'h65;
    localparam logic [7:0] FC_DUMP_REC = 8'h66;
    localparam logic [7:0] FC_EXC_FLAG = 8'h80;

    // Diagnostic subfunctions; 0B..12 select the counters in order
    localparam logic [15:0] SUB_CLEAR = 16'h000A;
    localparam logic [15:0] SUB_CNT_FIRST = 16'h000B;
    localparam logic [15:0] SUB_CNT_LAST = 16'h0012;

    // Stream subfunctions
    localparam logic [7:0] STRM_START = 8'h55;
    localparam logic [7:0] STRM_NEXT = 8'hAA;

    // Exception codes
    localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
    localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
    localparam logic [7:0] EXC_ILL_VALUE = 8'h03;

    // Frame layout and limits
    localparam logic [7:0] BCAST_ADDR = 8'h00;
    localparam logic [15:0] RD_CNT_MAX = 16'h007D;
    localparam logic [7:0] LEN_MIN = 8'h04;
    localparam logic [7:0] LEN_FIXED = 8'h08;
    localparam logic [7:0] LEN_STRM_NEXT = 8'h05;
    localparam logic [7:0] LEN_STRM_REC = 8'h07;
    localparam logic [7:0] RX_KEEP = 8'h08;
    localparam logic [7:0] STRM_WORDS = 8'h08;
    localparam int TX_DEPTH = 256;

    // Object spaces seen by the object store
    localparam logic [1:0] SPACE_HOLD = 2'h0;
    localparam logic [1:0] SPACE_INPUT = 2'h1;
    localparam logic [1:0] SPACE_DICT = 2'h2;
    localparam logic [1:0] SPACE_REC = 2'h3;

    // Counter indexes
    localparam int CNT_BUS = 0;
    localparam int CNT_COMM = 1;
    localparam int CNT_EXC = 2;
    localparam int CNT_SRV = 3;
    localparam int CNT_NORESP = 4;
    localparam int CNT_BUSY = 6;
    localparam int CNT_OVR = 7;

    // Checksum
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    localparam logic [15:0] CRC_POLY = 16'hA001;

    typedef enum logic [2:0] {
        ST_IDLE, ST_EXEC, ST_RD_WAIT, ST_WR_WAIT, ST_EXC, ST_DONE, ST_SEND
    } mrs_state_t;

    // One byte through the reflected CRC-16
    function automatic logic [15:0] mrs_crc_byte(input logic [15:0] crc,
                                                 input logic [7:0] data);
        logic [15:0] c;
        c = crc ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction

endpackage

// ### sim/mrs_store.sv
// Object store model facing the interpreter's object port
module mrs_store (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [15:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o,
    output logic ack_o,
    output logic err_o,
    output logic [15:0] last_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] dly;
    logic go;
    logic bad;
    // Access due now; top nibble F is an absent object
    assign go = (rd_i || wr_i) && !ack_o && !err_o && dly == 2'h0;
    assign bad = addr_i[15:12] == 4'hF;
    // Data valid only with acknowledge, scrambled otherwise
    assign rdata_o = addr_i ^ (ack_o ? 16'hA5A5 : 16'h5A5A);
    // Prompt or slow answer, refusal of absent objects
    always_ff @(posedge clk_i) begin
        ack_o <= !rst_i && go && !bad;
        err_o <= !rst_i && go && bad;
        if (rst_i || ack_o || err_o) begin
            dly <= 2'($urandom % 3);
        end else if (rd_i || wr_i) begin
            dly <= dly - 2'(dly != 2'h0);
        end
        if (rst_i) begin
            last_o <= 16'h0000;
        end else if (go && wr_i && !bad) begin
            last_o <= wdata_i;
        end
    end
endmodule

// ### sim/mrs_slave_test.sv
// Self-checking bench for the request interpreter
module mrs_slave_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef logic [7:0] mrs_bytes_t[$];
    logic clk = 0;
    logic rst = 1;
    logic rxv = 0;
    logic rxe = 0;
    logic ovr = 0;
    logic rdy = 0;
    logic [7:0] rxd = 8'h00;
    logic txv, txl, ord, owr, ack, err, busy;
    logic [1:0] sp;
    logic [7:0] txd;
    logic [15:0] oa, owd, oix, rdat, diag, last;
    int failures = 0;
    int num_checks = 0;
    always #25 clk = ~clk;
    mrs_slave DUT (.CLK_SYS_I(clk), .SYS_RST_I(rst), .NODE_ADDR_I(8'h05),
        .RX_VALID_I(rxv), .RX_DATA_I(rxd), .RX_FRAME_END_I(rxe),
        .RX_OVERRUN_I(ovr), .TX_VALID_O(txv), .TX_DATA_O(txd),
        .TX_LAST_O(txl), .TX_READY_I(rdy), .OBJ_RD_O(ord),
        .OBJ_WR_O(owr), .OBJ_SPACE_O(sp), .OBJ_ADDR_O(oa),
        .OBJ_WDATA_O(owd), .OBJ_INDEX_O(oix), .OBJ_RDATA_I(rdat),
        .OBJ_ACK_I(ack), .OBJ_ERR_I(err), .BUSY_O(busy), .DIAG_O(diag));
    mrs_store store (.clk_i(clk), .rst_i(rst), .rd_i(ord), .wr_i(owr),
        .addr_i(oa), .wdata_i(owd), .rdata_o(rdat), .ack_o(ack),
        .err_o(err), .last_o(last));
    // Frame with check bytes appended low first
    function automatic mrs_bytes_t crc(mrs_bytes_t q);
        logic [15:0] c;
        c = 16'hFFFF;
        foreach (q[i]) begin
            c ^= {8'h00, q[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
        end
        return {q, c[7:0], c[15:8]};
    endfunction
    function automatic mrs_bytes_t b(logic [47:0] v, int n);
        mrs_bytes_t q;
        for (int i = n - 1; i >= 0; i--) q.push_back(v[i*8 +: 8]);
        return q;
    endfunction
    task automatic chk(string s, logic [15:0] e, logic [15:0] v);
        num_checks++;
        if (v !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", s, e, v);
        end
    endtask
    task automatic end_of_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic send(mrs_bytes_t f);
        foreach (f[i]) begin
            @(posedge clk) #1;
            rxv = 1;
            rxd = f[i];
        end
        @(posedge clk) #1;
        rxv = 0;
        rxe = 1;
        @(posedge clk) #1;
        rxe = 0;
    endtask
    // Collect the reply under random stalls
    task automatic reply(mrs_bytes_t e);
        int k;
        k = 0;
        // One slave on this bus, so no turnaround gap is owed here
        repeat (800) begin
            @(posedge clk) #1;
            rdy = ($urandom % 4) != 0;
            @(negedge clk);
            if (txv === 1'b1 && rdy) begin
                chk("tx byte", k < e.size() ? e[k] : 16'hFFFF, txd);
                chk("tx last", 16'(k == e.size() - 1), txl);
                k++;
            end
        end
        chk("reply length", 16'(e.size()), 16'(k));
        chk("busy", 16'h0000, busy);
    endtask
    task automatic xchg(logic [47:0] r, int n, logic [47:0] e, int m);
        mrs_bytes_t none;
        send(crc(b(r, n)));
        if (m > 0) reply(crc(b(e, m)));
        else reply(none);
    endtask
    initial begin
        logic [15:0] a;
        logic [15:0] v;
        logic [7:0] n;
        mrs_bytes_t q;
        void'($urandom(32'h75b290b6));
        repeat (2) @(posedge clk);
        #1 rst = 0;
        xchg(48'h050617700001, 6, 48'h050617700001, 6);
        // Reads of one, the maximum and random counts
        for (int j = 0; j < 8; j++) begin
            a = 16'($urandom % 16'hE000);
            n = j % 4 == 1 ? 8'h7D : 8'(j % 4 == 0 ? 1 : 1 + $urandom % 7);
            q = b({8'h05, j < 4 ? 8'h03 : 8'h04, a, 8'h00, n}, 6);
            send(crc(q));
            q = {q[0], q[1], 8'(2 * n)};
            for (int i = 0; i < n; i++) begin
                v = (a + 16'(i)) ^ 16'hA5A5;
                q = {q, v[15:8], v[7:0]};
            end
            reply(crc(q));
        end
        xchg(48'h050310000000, 6, 48'h058303, 3);
        xchg(48'h05041000007E, 6, 48'h058403, 3);
        xchg(48'h0503F0000001, 6, 48'h058302, 3);
        xchg(48'h0506F1231234, 6, 48'h058602, 3);
        xchg(48'h050800130000, 6, 48'h058801, 3);
        xchg(48'h0565AA, 3, 48'h05E503, 3);
        xchg(48'h0566AA, 3, 48'h05E603, 3);
        // Dictionary start and next, then a record start
        for (int s = 0; s < 3; s++) begin
            q = b(s == 2 ? 48'h0566551234 : (s == 0 ? 48'h056555 :
                48'h0565AA), s == 2 ? 5 : 3);
            send(crc(q));
            q = {q[0], q[1], q[2], 8'h10};
            for (int i = 0; i < 8; i++) begin
                v = 16'(s == 1 ? 8 + i : i) ^ 16'hA5A5;
                q = {q, v[7:0], v[15:8]};
            end
            reply(crc(q));
        end
        chk("record index", 16'h1234, oix);
        chk("record space", 16'h0003, 16'(sp));
        xchg(48'h000612340BEE, 6, 0, 0);
        chk("broadcast write", 16'h0BEE, last);
        xchg(48'h070612340000, 6, 0, 0);
        xchg(48'h0508000A0000, 6, 48'h0508000A0000, 6);
        chk("diag cleared", 16'h0000, diag);
        q = crc(b(48'h050800120000, 6));
        q[7] = ~q[7];
        xchg(48'h0507, 0, 0, 0);
        send(q);
        repeat (3) begin
            @(posedge clk) #1 ovr = 1;
            @(posedge clk) #1 ovr = 0;
        end
        xchg(48'h050700000000, 6, 48'h058701, 3);
        // Counters 0B to 12 after the clear, one nibble each
        for (int i = 0; i < 8; i++) begin
            n = 8'h0B + 8'(i);
            v = 16'((32'h30004121 >> (4 * i)) & 32'h0000000F);
            xchg({24'h050800, n, 16'h0}, 6, {24'h050800, n, v}, 6);
        end
        chk("diag bits", 16'h0003, diag);
        end_of_test();
    end
    // Hang guard well beyond the expected run length
    initial begin
        #3000000;
        failures++;
        end_of_test();
    end
endmodule
